//--- core/sdbk_regs.svh
`ifndef SDBK_REGS_SVH
`define SDBK_REGS_SVH
// ----------------------------------------
// mode word fields on the address lines
// ----------------------------------------
`define SDBK_MODE_BL_LSB      0
`define SDBK_MODE_BL_MSB      2
`define SDBK_MODE_ORDER_BIT   3
`define SDBK_MODE_CL_LSB      4
`define SDBK_MODE_CL_MSB      6
// ----------------------------------------
// burst length codes and reset values
// ----------------------------------------
`define SDBK_BL_CODE_1        3'h0
`define SDBK_BL_CODE_2        3'h1
`define SDBK_BL_CODE_4        3'h2
`define SDBK_BL_CODE_8        3'h3
`define SDBK_BL_CODE_PAGE     3'h7
`define SDBK_BL_RESET         3'h0
`define SDBK_CL_RESET         3'h2
`define SDBK_PAGE_BEATS       10'h200
// ----------------------------------------
// timing counts in clocks
// ----------------------------------------
`define SDBK_LAST_DATA_TO_CLOSE_CLKS 2'h2
`endif

//--- core/sdbk_pkg.sv
package sdbk_pkg;
  typedef enum logic [1:0] {
    PWR_NORMAL,
    PWR_SELF_REFRESH,
    PWR_POWER_DOWN,
    PWR_SUSPEND
  } sdbk_pwr_t;

  typedef enum logic [3:0] {
    CMD_DESELECT,
    CMD_NOP,
    CMD_ACTIVATE,
    CMD_READ,
    CMD_WRITE,
    CMD_CLOSE,
    CMD_BURST_STOP,
    CMD_AUTO_REFRESH,
    CMD_MODE_SET
  } sdbk_cmd_t;
endpackage

//--- core/sdbk_bank.sv
// one bank open flag
module sdbk_bank (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // open and close strobes
  input  wire logic i_open,
  input  wire logic i_close,
  // state
  output logic      o_open
);
  logic open_ff;
  logic nxt_open;

  always_comb begin
    nxt_open = open_ff;
    if (i_close) begin
      nxt_open = 1'b0;
    end
    if (i_open) begin
      nxt_open = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      open_ff <= 1'b0;
    end else begin
      open_ff <= nxt_open;
    end
  end

  assign o_open = open_ff;
endmodule

//--- core/sdbk_ctrl.sv
`include "sdbk_regs.svh"
module sdbk_ctrl (
  // clock and reset
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_ARST_N,
  // command pins
  input  wire logic       I_CS_N,
  input  wire logic       I_RAS_N,
  input  wire logic       I_CAS_N,
  input  wire logic       I_WE_N,
  input  wire logic       I_CKE,
  // address pins
  input  wire logic       I_BANK_SEL_LO,
  input  wire logic       I_BANK_SEL_HI,
  input  wire logic       I_AUTO_CLOSE_ADDR_BIT,
  input  wire logic [9:0] I_ADDR,
  // bank and burst state
  output logic      [3:0] O_BANK_OPEN,
  output logic      [3:0] O_CLOSE_START,
  output logic            O_BURST_ACTIVE,
  output logic            O_BURST_WRITE,
  output logic      [1:0] O_BURST_BANK,
  output logic      [9:0] O_BURST_COL,
  output logic            O_AUTO_CLOSE,
  // power state
  output logic            O_SELF_REFRESH,
  output logic            O_POWER_DOWN,
  output logic            O_CLK_SUSPEND,
  // events and mode
  output logic            O_REFRESH,
  output logic            O_CMD_IGNORED,
  output logic      [2:0] O_BURST_LEN,
  output logic            O_INTERLEAVE,
  output logic      [2:0] O_CAS_LAT
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  sdbk_pkg::sdbk_pwr_t pwr_ff,      nxt_pwr;
  logic                cke_prev_ff;
  logic                burst_ff,    nxt_burst;
  logic                wr_ff,       nxt_wr;
  logic                auto_ff,     nxt_auto;
  logic                page_ff,     nxt_page;
  logic                closed_ff,   nxt_closed;
  logic [1:0]          bank_ff,     nxt_bank;
  logic [9:0]          col_ff,      nxt_col;
  logic [9:0]          cnt_ff,      nxt_cnt;
  logic [1:0]          wr_wait_ff,  nxt_wr_wait;
  logic [3:0]          close_ff,    nxt_close;
  logic                refresh_ff,  nxt_refresh;
  logic                ignored_ff,  nxt_ignored;
  logic [2:0]          bl_ff,       nxt_bl;
  logic                order_ff,    nxt_order;
  logic [2:0]          cl_ff,       nxt_cl;
  logic [3:0]          open_vec;
  logic [3:0]          open_req;
  logic [3:0]          close_req;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  sdbk_pkg::sdbk_cmd_t cmd;
  logic       run;
  logic       lock;
  logic       any_open;
  logic       start;
  logic       active;
  logic       fire_rd;
  logic       fire_wr;
  logic       bad;
  logic [1:0] sel;
  logic [3:0] sel_hot;
  logic [9:0] beats;
  logic [9:0] rem_next;
  logic [9:0] lead;

  assign sel      = {I_BANK_SEL_HI, I_BANK_SEL_LO};
  assign sel_hot  = 4'h1 << sel;
  assign any_open = |open_vec;
  assign run      = cke_prev_ff && (pwr_ff == sdbk_pkg::PWR_NORMAL);
  assign lock     = burst_ff && auto_ff;
  assign lead     = {7'h00, cl_ff} - 10'h001;

  always_comb begin
    if (I_CS_N) begin
      cmd = sdbk_pkg::CMD_DESELECT;
    end else begin
      case ({I_RAS_N, I_CAS_N, I_WE_N})
        3'h3:    cmd = sdbk_pkg::CMD_ACTIVATE;
        3'h5:    cmd = sdbk_pkg::CMD_READ;
        3'h4:    cmd = sdbk_pkg::CMD_WRITE;
        3'h2:    cmd = sdbk_pkg::CMD_CLOSE;
        3'h6:    cmd = sdbk_pkg::CMD_BURST_STOP;
        3'h1:    cmd = sdbk_pkg::CMD_AUTO_REFRESH;
        3'h0:    cmd = sdbk_pkg::CMD_MODE_SET;
        default: cmd = sdbk_pkg::CMD_NOP;
      endcase
    end
  end

  always_comb begin
    case (bl_ff)
      `SDBK_BL_CODE_2:    beats = 10'h002;
      `SDBK_BL_CODE_4:    beats = 10'h004;
      `SDBK_BL_CODE_8:    beats = 10'h008;
      `SDBK_BL_CODE_PAGE: beats = `SDBK_PAGE_BEATS;
      default:            beats = 10'h001;
    endcase
  end

  // protocol misuse by the controller is refused
  always_comb begin
    bad = 1'b0;
    case (cmd)
      sdbk_pkg::CMD_READ, sdbk_pkg::CMD_WRITE: begin
        bad = lock || !open_vec[sel]
           || (wr_wait_ff != 2'h0 && sel == bank_ff)
           || (I_AUTO_CLOSE_ADDR_BIT && (bl_ff == `SDBK_BL_CODE_PAGE));
      end
      sdbk_pkg::CMD_CLOSE:        bad = lock;
      sdbk_pkg::CMD_ACTIVATE:     bad = open_vec[sel];
      sdbk_pkg::CMD_BURST_STOP:   bad = !(burst_ff && page_ff);
      sdbk_pkg::CMD_AUTO_REFRESH: bad = any_open || burst_ff;
      sdbk_pkg::CMD_MODE_SET:     bad = any_open || burst_ff;
      default:                    bad = 1'b0;
    endcase
  end

  assign start    = run && !bad
                 && (cmd == sdbk_pkg::CMD_READ || cmd == sdbk_pkg::CMD_WRITE);
  assign active   = start || (burst_ff && run);
  assign rem_next = start ? beats - 10'h001 : cnt_ff - 10'h001;
  // a new burst must not see the close flag of the previous one
  assign fire_rd  = active && (start || !closed_ff) && !nxt_wr && nxt_auto
                 && (rem_next <= lead);
  assign fire_wr  = run && (wr_wait_ff == 2'h1);

  // ----------------------------------------
  // burst and close logic
  // ----------------------------------------
  always_comb begin
    nxt_burst   = burst_ff;
    nxt_wr      = wr_ff;
    nxt_auto    = auto_ff;
    nxt_page    = page_ff;
    nxt_bank    = bank_ff;
    nxt_col     = col_ff;
    nxt_cnt     = cnt_ff;
    nxt_closed  = closed_ff;
    nxt_wr_wait = wr_wait_ff;
    nxt_refresh = 1'b0;
    nxt_ignored = run && bad;
    nxt_bl      = bl_ff;
    nxt_order   = order_ff;
    nxt_cl      = cl_ff;
    open_req    = 4'h0;
    close_req   = 4'h0;
    if (start) begin
      nxt_wr     = (cmd == sdbk_pkg::CMD_WRITE);
      nxt_auto   = I_AUTO_CLOSE_ADDR_BIT;
      nxt_page   = (bl_ff == `SDBK_BL_CODE_PAGE);
      nxt_bank   = sel;
      nxt_col    = I_ADDR;
      nxt_closed = 1'b0;
      nxt_cnt    = rem_next;
      nxt_burst  = (rem_next != 10'h000);
    end else if (burst_ff && run && !page_ff) begin
      nxt_cnt   = rem_next;
      nxt_burst = (rem_next != 10'h000);
    end
    if (fire_rd) begin
      nxt_closed = 1'b1;
      close_req  = close_req | (4'h1 << nxt_bank);
    end
    if (run && wr_wait_ff != 2'h0) begin
      nxt_wr_wait = wr_wait_ff - 2'h1;
    end
    if (fire_wr) begin
      close_req = close_req | (4'h1 << bank_ff);
    end
    if (active && nxt_wr && nxt_auto && !nxt_page && rem_next == 10'h000) begin
      nxt_wr_wait = `SDBK_LAST_DATA_TO_CLOSE_CLKS;
      nxt_closed  = 1'b1;
    end
    if (run && !bad) begin
      case (cmd)
        sdbk_pkg::CMD_ACTIVATE: open_req = sel_hot;
        sdbk_pkg::CMD_CLOSE: begin
          close_req = close_req | (I_AUTO_CLOSE_ADDR_BIT ? 4'hf : sel_hot);
          if (I_AUTO_CLOSE_ADDR_BIT || sel == bank_ff) begin
            nxt_burst = 1'b0;
          end
        end
        sdbk_pkg::CMD_BURST_STOP:   nxt_burst = 1'b0;
        sdbk_pkg::CMD_AUTO_REFRESH: nxt_refresh = I_CKE;
        sdbk_pkg::CMD_MODE_SET: begin
          nxt_bl    = I_ADDR[`SDBK_MODE_BL_MSB:`SDBK_MODE_BL_LSB];
          nxt_order = I_ADDR[`SDBK_MODE_ORDER_BIT];
          nxt_cl    = I_ADDR[`SDBK_MODE_CL_MSB:`SDBK_MODE_CL_LSB];
        end
        default: nxt_burst = nxt_burst;
      endcase
    end
    nxt_close = close_req;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      burst_ff   <= 1'b0;
      wr_ff      <= 1'b0;
      auto_ff    <= 1'b0;
      page_ff    <= 1'b0;
      bank_ff    <= 2'h0;
      col_ff     <= 10'h000;
      cnt_ff     <= 10'h000;
      closed_ff  <= 1'b0;
      wr_wait_ff <= 2'h0;
      close_ff   <= 4'h0;
      refresh_ff <= 1'b0;
      ignored_ff <= 1'b0;
      bl_ff      <= `SDBK_BL_RESET;
      order_ff   <= 1'b0;
      cl_ff      <= `SDBK_CL_RESET;
    end else begin
      burst_ff   <= nxt_burst;
      wr_ff      <= nxt_wr;
      auto_ff    <= nxt_auto;
      page_ff    <= nxt_page;
      bank_ff    <= nxt_bank;
      col_ff     <= nxt_col;
      cnt_ff     <= nxt_cnt;
      closed_ff  <= nxt_closed;
      wr_wait_ff <= nxt_wr_wait;
      close_ff   <= nxt_close;
      refresh_ff <= nxt_refresh;
      ignored_ff <= nxt_ignored;
      bl_ff      <= nxt_bl;
      order_ff   <= nxt_order;
      cl_ff      <= nxt_cl;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bank
      sdbk_bank u_bank (
        .i_clk    (I_CLK_SYS),
        .i_arst_n (I_ARST_N),
        .i_open   (open_req[g]),
        .i_close  (close_req[g]),
        .o_open   (open_vec[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // power states
  // ----------------------------------------
  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      sdbk_pkg::PWR_NORMAL: begin
        if (cke_prev_ff && !I_CKE) begin
          if (cmd == sdbk_pkg::CMD_AUTO_REFRESH && !any_open && !burst_ff) begin
            nxt_pwr = sdbk_pkg::PWR_SELF_REFRESH;
          end else if (any_open || burst_ff) begin
            nxt_pwr = sdbk_pkg::PWR_SUSPEND;
          end else begin
            nxt_pwr = sdbk_pkg::PWR_POWER_DOWN;
          end
        end
      end
      sdbk_pkg::PWR_SELF_REFRESH,
      sdbk_pkg::PWR_POWER_DOWN,
      sdbk_pkg::PWR_SUSPEND: begin
        if (I_CKE) begin
          nxt_pwr = sdbk_pkg::PWR_NORMAL;
        end
      end
      default: nxt_pwr = sdbk_pkg::PWR_NORMAL;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pwr_ff      <= sdbk_pkg::PWR_NORMAL;
      cke_prev_ff <= 1'b0;
    end else begin
      pwr_ff      <= nxt_pwr;
      cke_prev_ff <= I_CKE;
    end
  end

  assign O_BANK_OPEN    = open_vec;
  assign O_CLOSE_START  = close_ff;
  assign O_BURST_ACTIVE = burst_ff;
  assign O_BURST_WRITE  = wr_ff;
  assign O_BURST_BANK   = bank_ff;
  assign O_BURST_COL    = col_ff;
  assign O_AUTO_CLOSE   = auto_ff;
  assign O_SELF_REFRESH = (pwr_ff == sdbk_pkg::PWR_SELF_REFRESH);
  assign O_POWER_DOWN   = (pwr_ff == sdbk_pkg::PWR_POWER_DOWN);
  assign O_CLK_SUSPEND  = (pwr_ff == sdbk_pkg::PWR_SUSPEND);
  assign O_REFRESH      = refresh_ff;
  assign O_CMD_IGNORED  = ignored_ff;
  assign O_BURST_LEN    = bl_ff;
  assign O_INTERLEAVE   = order_ff;
  assign O_CAS_LAT      = cl_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_wr_close_gap: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (wr_wait_ff == 2'h2 && run) ##1 run |=> (close_ff == (4'h1 << $past(bank_ff))))
    else $error("write auto close not two clocks after data");
  a_susp_freeze: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (pwr_ff == sdbk_pkg::PWR_SUSPEND && !cke_prev_ff) |=> $stable(cnt_ff) && $stable(open_vec))
    else $error("burst advanced while suspended");
  a_susp_exit: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (pwr_ff == sdbk_pkg::PWR_SUSPEND && I_CKE) |=> run)
    else $error("suspend did not end one clock after gate high");
  a_sr_hold: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (pwr_ff == sdbk_pkg::PWR_SELF_REFRESH && !I_CKE) |=> O_SELF_REFRESH && !O_REFRESH)
    else $error("self refresh left or command taken");
  a_close_all: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (run && cmd == sdbk_pkg::CMD_CLOSE && I_AUTO_CLOSE_ADDR_BIT && !lock) |=> open_vec == 4'h0)
    else $error("close all left a bank open");
  a_close_one: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (run && cmd == sdbk_pkg::CMD_CLOSE && !I_AUTO_CLOSE_ADDR_BIT && !lock)
    |=> !open_vec[$past(sel)])
    else $error("selected bank not closed");
  a_nop_keeps: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (burst_ff && run && !page_ff && cnt_ff > 10'h001
     && (cmd == sdbk_pkg::CMD_NOP || cmd == sdbk_pkg::CMD_DESELECT))
    |=> burst_ff && cnt_ff == $past(cnt_ff) - 10'h001)
    else $error("no-operation disturbed a burst");
  a_pd_in_burst: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (run && !I_CKE && burst_ff) |=> O_CLK_SUSPEND)
    else $error("power down entered during burst");
  a_pd_idle: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (run && !I_CKE && !any_open && !burst_ff && cmd != sdbk_pkg::CMD_AUTO_REFRESH)
    |=> O_POWER_DOWN)
    else $error("idle gate low did not enter power down");
  a_sr_entry: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (run && !I_CKE && !any_open && !burst_ff && cmd == sdbk_pkg::CMD_AUTO_REFRESH)
    |=> O_SELF_REFRESH)
    else $error("self refresh not entered");
  a_no_auto_open: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (start && !I_AUTO_CLOSE_ADDR_BIT) |=> open_vec[$past(sel)] && !close_ff[$past(sel)])
    else $error("bank closed without auto close");
  a_cmd_qual: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (!run) |=> $stable(open_vec) && !O_REFRESH && !O_CMD_IGNORED)
    else $error("command taken without gate high before");
  a_rd_lead: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (start && cmd == sdbk_pkg::CMD_READ && I_AUTO_CLOSE_ADDR_BIT && beats <= cl_ff)
    |=> close_ff == (4'h1 << $past(sel)))
    else $error("short read auto close not started at once");
endmodule

//--- verification/sdbk_ctl_model.sv
module sdbk_ctl_model (
  // clock
  input  wire logic       i_clk,
  // command pins
  output logic            o_cs_n,
  output logic            o_ras_n,
  output logic            o_cas_n,
  output logic            o_we_n,
  output logic            o_cke,
  // address pins
  output logic            o_bank_lo,
  output logic            o_bank_hi,
  output logic            o_ac,
  output logic      [9:0] o_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // pins at time zero
  // ----------------------------------------
  initial begin
    {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_cke} = 5'h1f;
    {o_bank_hi, o_bank_lo, o_ac, o_addr} = 13'h0;
  end
  // ----------------------------------------
  // one command for one edge, then no-operation
  // ----------------------------------------
  task automatic drive(input sdbk_pkg::sdbk_cmd_t cmd, input logic [1:0] bank,
                       input logic ac, input logic [9:0] addr, input logic cke);
    logic [2:0] s;
    case (cmd)
      sdbk_pkg::CMD_ACTIVATE:     s = 3'h3;
      sdbk_pkg::CMD_READ:         s = 3'h5;
      sdbk_pkg::CMD_WRITE:        s = 3'h4;
      sdbk_pkg::CMD_CLOSE:        s = 3'h2;
      sdbk_pkg::CMD_BURST_STOP:   s = 3'h6;
      sdbk_pkg::CMD_AUTO_REFRESH: s = 3'h1;
      sdbk_pkg::CMD_MODE_SET:     s = 3'h0;
      sdbk_pkg::CMD_NOP:          s = 3'h7;
      default:                    s = ~{o_ras_n, o_cas_n, o_we_n};
    endcase
    @(negedge i_clk);
    o_cs_n = (cmd == sdbk_pkg::CMD_DESELECT);
    {o_ras_n, o_cas_n, o_we_n} = s;
    o_cke = cke;
    if (cmd inside {sdbk_pkg::CMD_NOP, sdbk_pkg::CMD_DESELECT}) begin
      {o_bank_hi, o_bank_lo, o_ac, o_addr} = ~{o_bank_hi, o_bank_lo, o_ac, o_addr};
    end else begin
      {o_bank_hi, o_bank_lo, o_ac, o_addr} = {bank, ac, addr};
    end
    @(negedge i_clk);
    o_cs_n = 1'b0;
    {o_ras_n, o_cas_n, o_we_n} = 3'h7;
    {o_bank_hi, o_bank_lo, o_ac, o_addr} = ~{o_bank_hi, o_bank_lo, o_ac, o_addr};
  endtask
endmodule

//--- verification/sdbk_ctrl_tb_top.sv
`include "sdbk_regs.svh"
`define SDBK_CHK(nm, ex, gt) \
  begin \
    samples_checked++; \
    if ((gt) !== (ex)) begin \
      error_cnt++; \
      $display("BAD %s exp %0h got %0h", nm, ex, gt); \
    end \
  end
module sdbk_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OPEN_HOLD = 3;
  localparam int CLOSE_OPEN = 2;
  localparam int EXIT_REC = 4;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cs_n, ras_n, cas_n, we_n, cke, bs_lo, bs_hi, ac;
  logic  [9:0] addr, burst_col;
  logic  [3:0] bank_open, close_start, exp_open;
  logic        burst_active, burst_write, auto_close, self_ref, pwr_down, clk_susp;
  logic        refresh, cmd_ign, interleave;
  logic  [2:0] burst_len, cas_lat, cl;
  logic  [1:0] burst_bank, b;
  logic [31:0] r;
  int          seed = 89;
  int          n;
  int          error_cnt = 0;
  int          samples_checked = 0;
  logic        t_wr [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic  [2:0] t_bl [4] = '{`SDBK_BL_CODE_8, `SDBK_BL_CODE_8, `SDBK_BL_CODE_1, `SDBK_BL_CODE_2};
  logic  [2:0] t_cl [4] = '{3'h2, 3'h3, 3'h3, 3'h2};
  logic  [2:0] codes [5] = '{`SDBK_BL_CODE_1, `SDBK_BL_CODE_2, `SDBK_BL_CODE_4,
                             `SDBK_BL_CODE_8, `SDBK_BL_CODE_PAGE};

  always #25 clk = ~clk;

  sdbk_ctl_model i_sdbk_ctl_model (.i_clk(clk), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_cke(cke), .o_bank_lo(bs_lo), .o_bank_hi(bs_hi),
    .o_ac(ac), .o_addr(addr));

  sdbk_ctrl i_sdbk_ctrl (.I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_CS_N(cs_n), .I_RAS_N(ras_n),
    .I_CAS_N(cas_n), .I_WE_N(we_n), .I_CKE(cke), .I_BANK_SEL_LO(bs_lo),
    .I_BANK_SEL_HI(bs_hi), .I_AUTO_CLOSE_ADDR_BIT(ac), .I_ADDR(addr),
    .O_BANK_OPEN(bank_open), .O_CLOSE_START(close_start), .O_BURST_ACTIVE(burst_active),
    .O_BURST_WRITE(burst_write), .O_BURST_BANK(burst_bank), .O_BURST_COL(burst_col),
    .O_AUTO_CLOSE(auto_close), .O_SELF_REFRESH(self_ref), .O_POWER_DOWN(pwr_down),
    .O_CLK_SUSPEND(clk_susp), .O_REFRESH(refresh), .O_CMD_IGNORED(cmd_ign),
    .O_BURST_LEN(burst_len), .O_INTERLEAVE(interleave), .O_CAS_LAT(cas_lat));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic int beats(input logic [2:0] code);
    case (code)
      3'h1: return 2;
      3'h2: return 4;
      3'h3: return 8;
      3'h7: return 512;
      default: return 1;
    endcase
  endfunction

  function automatic int close_k(input logic wr, input int l, input int lat);
    if (wr) return l + 1;
    return (l > lat) ? l - lat : 0;
  endfunction

  task automatic send(input sdbk_pkg::sdbk_cmd_t c, input logic [1:0] bk, input logic ac_bit,
                      input logic [9:0] a, input logic k);
    i_sdbk_ctl_model.drive(c, bk, ac_bit, a, k);
  endtask

  task automatic idle(input int cnt);
    repeat (cnt) send(sdbk_pkg::CMD_NOP, 2'h0, 1'b0, 10'h0, 1'b1);
  endtask

  task automatic mode(input logic [2:0] code, input logic ord, input logic [2:0] lat);
    send(sdbk_pkg::CMD_MODE_SET, 2'h0, 1'b0, {3'h0, lat, ord, code}, 1'b1);
    `SDBK_CHK("mode", {code, ord, lat}, {burst_len, interleave, cas_lat})
  endtask

  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    `SDBK_CHK("reset", 17'h00100, {bank_open, burst_len, cas_lat, interleave, self_ref, pwr_down, clk_susp, burst_active, refresh, cmd_ign})
    arst_n = 1'b1;
    idle(2);
    foreach (codes[i]) begin
      r = $random(seed);
      cl = (r[1:0] == 2'h0) ? 3'h3 : {1'b0, r[1:0]};
      mode(codes[i], r[2], cl);
    end
    exp_open = 4'h0;
    repeat (24) begin
      r = $random(seed);
      b = r[1:0];
      if (r[2]) begin
        send(sdbk_pkg::CMD_ACTIVATE, b, 1'b0, r[12:3], 1'b1);
        `SDBK_CHK("act_twice", exp_open[b], cmd_ign)
        exp_open[b] = 1'b1;
      end else begin
        send(sdbk_pkg::CMD_CLOSE, b, r[3], 10'h0, 1'b1);
        exp_open = r[3] ? 4'h0 : exp_open & ~(4'h1 << b);
      end
      idle(1);
      `SDBK_CHK("open_mask", exp_open, bank_open)
    end
    send(sdbk_pkg::CMD_CLOSE, 2'h0, 1'b1, 10'h0, 1'b1);
    send(sdbk_pkg::CMD_READ, 2'h0, 1'b0, 10'h0, 1'b1);
    `SDBK_CHK("rd_closed", 5'h10, {cmd_ign, bank_open})
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      b = r[1:0];
      mode(t_bl[i], 1'b0, t_cl[i]);
      send(sdbk_pkg::CMD_ACTIVATE, b, 1'b0, r[25:16], 1'b1);
      idle(OPEN_HOLD);
      send(t_wr[i] ? sdbk_pkg::CMD_WRITE : sdbk_pkg::CMD_READ, b, 1'b1, r[13:4], 1'b1);
      `SDBK_CHK("burst", {t_wr[i], b, r[13:4], 1'b1}, {burst_write, burst_bank, burst_col, auto_close})
      n = 0;
      if (t_wr[i] && t_bl[i] == 3'h3) begin
        send(sdbk_pkg::CMD_READ, b, 1'b0, 10'h0, 1'b1);
        `SDBK_CHK("no_cut", 1'b1, cmd_ign)
        n = 2;
      end
      while (close_start[b] !== 1'b1 && n < 600) begin
        @(negedge clk);
        n++;
      end
      `SDBK_CHK("close_at", close_k(t_wr[i], beats(t_bl[i]), int'(t_cl[i])), n)
      `SDBK_CHK("closed", 1'b0, bank_open[b])
      idle(CLOSE_OPEN);
    end
    mode(`SDBK_BL_CODE_PAGE, 1'b0, 3'h2);
    send(sdbk_pkg::CMD_ACTIVATE, 2'h1, 1'b0, 10'h0, 1'b1);
    idle(OPEN_HOLD);
    send(sdbk_pkg::CMD_READ, 2'h1, 1'b1, 10'h0, 1'b1);
    `SDBK_CHK("page_auto", 2'b10, {cmd_ign, burst_active})
    send(sdbk_pkg::CMD_READ, 2'h1, 1'b0, 10'h5, 1'b1);
    send(sdbk_pkg::CMD_DESELECT, 2'h1, 1'b0, 10'h0, 1'b1);
    idle(1);
    `SDBK_CHK("page_run", 1'b1, burst_active)
    send(sdbk_pkg::CMD_DESELECT, 2'h1, 1'b0, 10'h0, 1'b0);
    `SDBK_CHK("suspend", 2'b10, {clk_susp, pwr_down})
    send(sdbk_pkg::CMD_ACTIVATE, 2'h2, 1'b0, 10'h0, 1'b0);
    `SDBK_CHK("susp_cmd", 2'b10, {clk_susp, bank_open[2]})
    send(sdbk_pkg::CMD_NOP, 2'h0, 1'b0, 10'h0, 1'b1);
    `SDBK_CHK("resume", 2'b01, {clk_susp, burst_active})
    send(sdbk_pkg::CMD_BURST_STOP, 2'h0, 1'b0, 10'h0, 1'b1);
    `SDBK_CHK("stop", 2'b10, {bank_open[1], burst_active})
    send(sdbk_pkg::CMD_BURST_STOP, 2'h0, 1'b0, 10'h0, 1'b1);
    `SDBK_CHK("stop_idle", 1'b1, cmd_ign)
    send(sdbk_pkg::CMD_CLOSE, 2'h0, 1'b1, 10'h0, 1'b1);
    `SDBK_CHK("all_closed", 4'h0, bank_open)
    send(sdbk_pkg::CMD_AUTO_REFRESH, 2'h0, 1'b0, 10'h0, 1'b0);
    `SDBK_CHK("self_ref", 2'b10, {self_ref, cmd_ign})
    send(sdbk_pkg::CMD_ACTIVATE, 2'h3, 1'b0, 10'h0, 1'b0);
    `SDBK_CHK("sr_hold", 5'h10, {self_ref, bank_open})
    send(sdbk_pkg::CMD_NOP, 2'h0, 1'b0, 10'h0, 1'b1);
    `SDBK_CHK("sr_exit", 1'b0, self_ref)
    idle(EXIT_REC);
    repeat (4) begin
      send(sdbk_pkg::CMD_AUTO_REFRESH, 2'h0, 1'b0, 10'h0, 1'b1);
      `SDBK_CHK("refresh", 1'b1, refresh)
    end
    send(sdbk_pkg::CMD_NOP, 2'h0, 1'b0, 10'h0, 1'b0);
    `SDBK_CHK("pwr_down", 2'b10, {pwr_down, clk_susp})
    send(sdbk_pkg::CMD_NOP, 2'h0, 1'b0, 10'h0, 1'b1);
    `SDBK_CHK("pd_exit", 1'b0, pwr_down)
    send(sdbk_pkg::CMD_ACTIVATE, 2'h0, 1'b0, 10'h0, 1'b1);
    `SDBK_CHK("after_pd", 4'h1, bank_open)
    close_out();
  end
endmodule
